// ### src/ssflag_defines.svh
`ifndef SSFLAG_DEFINES_SVH
`define SSFLAG_DEFINES_SVH
// Status bit positions
`define SSF_BIT_TX_HOLDING_EMPTY_FLAG   3'd0
`define SSF_BIT_RX_HOLDING_FULL_FLAG   3'd1
`define SSF_BIT_TXEMT   3'd2
`define SSF_BIT_PE      3'd3
`define SSF_BIT_OE      3'd4
`define SSF_BIT_FE      3'd5
`define SSF_BIT_DCD     3'd6
`define SSF_BIT_DSR     3'd7
// Bus decode: address and read level, then flags reset value
`define SSF_ADDR_STATUS 2'h1
`define SSF_RW_READ     1'b0
`define SSF_FLAGS_RESET 8'h00
`endif

// ### src/ssflag_pkg.sv
package ssflag_pkg;
  typedef enum logic [1:0] {
    SSF_ASYNC       = 2'b00,
    SSF_SYNC_NORMAL = 2'b01,
    SSF_SYNC_TRANSP = 2'b10
  } ssflag_mode_t;
  typedef enum logic [1:0] {
    SSF_HUNT  = 2'b00,
    SSF_SYNC2 = 2'b01,
    SSF_INSYN = 2'b10
  } ssflag_sync_t;
endpackage : ssflag_pkg

// ### src/ssflag_modem_watch.sv
`timescale 1ns/1ps
`include "ssflag_defines.svh"
// Flags any change on the two modem inputs, one cycle pulse.
module ssflag_modem_watch (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic dcd_n_in,
  input  wire logic dsr_n_in,
  output logic      change_out
);
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;
  logic       primed_r;
  logic       primed_nxt;
  logic       change_r;
  logic       change_nxt;

  always_comb begin
    prev_nxt   = {dsr_n_in, dcd_n_in};
    primed_nxt = 1'b1;
    // No change reported on the first sample after reset
    change_nxt = primed_r && (prev_r != {dsr_n_in, dcd_n_in});
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      prev_r   <= 2'b11;
      primed_r <= 1'b0;
      change_r <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
      change_r <= change_nxt;
    end
  end

  assign change_out = change_r;
endmodule : ssflag_modem_watch

// ### src/ssflag_status.sv
`timescale 1ns/1ps
`include "ssflag_defines.svh"
// Notes on behaviour
// - Status read clears modem-change; repeat means idle
// - No idle report before first character sent
// - Idle cleared by holding write or tx disable
// - Sync mode sets idle despite fill characters
// - Bit 3 flags parity error when enabled
// - Transparent, parity off: bit 3 is escape detect
// - Bit 3 clears on disable, reset-error; escape also on next char
// - Bit 4 set on holding register overrun
// - Overrun clears by reset-error or rx disable
// - Async bit 5 flags missing stop bit
// - Sync normal bit 5 flags sync character(s)
// - Transparent bit 5: initial sync, escape-sync pair
// - Bit 5 clear rules depend on mode
// - Bits 6,7 mirror inverted modem inputs
// - Bit 0 is holding register empty
// - Bit 1 is receive holding register full
// - Bit 2 is idle or modem change
module ssflag_status
  import ssflag_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  // Parallel bus
  input  wire logic       ce_n_in,
  input  wire logic [1:0] addr_in,
  input  wire logic       rw_in,
  input  wire logic       rx_hold_read_in,
  input  wire logic       reset_error_cmd_in,
  // Enables and mode
  input  wire logic       tx_enable_bit_in,
  input  wire logic       rx_enable_bit_in,
  input  wire logic       sync_mode_in,
  input  wire logic       single_sync_in,
  input  wire logic       transparent_select_in,
  input  wire logic       parity_enable_bit_in,
  // Transmitter events
  input  wire logic       tx_hold_write_in,
  input  wire logic       tx_hold_load_in,
  input  wire logic       tx_shift_done_in,
  // Receiver events
  input  wire logic       rx_char_valid_in,
  input  wire logic [7:0] rx_char_in,
  input  wire logic       rx_parity_err_in,
  input  wire logic       rx_stop_err_in,
  input  wire logic [7:0] first_sync_char_in,
  input  wire logic [7:0] second_sync_char_in,
  input  wire logic [7:0] escape_char_in,
  // Modem inputs, active low
  input  wire logic       dcd_n_in,
  input  wire logic       dsr_n_in,
  output logic [7:0]      line_status_out,
  output logic            tx_holding_empty_flag_n_out,
  output logic            rx_holding_full_flag_n_out,
  output logic            tx_idle_or_modem_change_n_out
);
  // ****************************************************
  // Mode and bus decode
  // ****************************************************
  ssflag_mode_t mode;
  logic         status_rd;
  logic         modem_change;

  always_comb begin
    if (!sync_mode_in) begin
      mode = SSF_ASYNC;
    end else if (transparent_select_in) begin
      mode = SSF_SYNC_TRANSP;
    end else begin
      mode = SSF_SYNC_NORMAL;
    end
  end

  assign status_rd = !ce_n_in && (addr_in == `SSF_ADDR_STATUS)
                     && (rw_in == `SSF_RW_READ);

  ssflag_modem_watch u_watch (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .dcd_n_in   (dcd_n_in),
    .dsr_n_in   (dsr_n_in),
    .change_out (modem_change)
  );

  // ****************************************************
  // Flag state
  // ****************************************************
  logic         thr_empty_r, thr_empty_nxt;
  logic         rhr_full_r, rhr_full_nxt;
  logic         tx_started_r, tx_started_nxt;
  logic         tx_idle_r, tx_idle_nxt;
  logic         mchg_r, mchg_nxt;
  logic         pe_r, pe_nxt;
  logic         esc_r, esc_nxt;
  logic         oe_r, oe_nxt;
  logic         fe_r, fe_nxt;
  logic         prev_esc_r, prev_esc_nxt;
  logic         tx_on_r, tx_on_nxt;
  ssflag_sync_t sync_r, sync_nxt;
  logic [7:0]   status_r, status_nxt;
  logic [2:0]   pins_r, pins_nxt;

  always_comb begin
    logic is_s1;
    logic is_s2;
    logic is_esc;
    logic sync_hit;
    is_s1    = rx_char_in == first_sync_char_in;
    is_s2    = rx_char_in == second_sync_char_in;
    is_esc   = rx_char_in == escape_char_in;
    sync_hit = 1'b0;

    thr_empty_nxt  = thr_empty_r;
    rhr_full_nxt   = rhr_full_r;
    tx_started_nxt = tx_started_r;
    tx_idle_nxt    = tx_idle_r;
    mchg_nxt       = mchg_r;
    pe_nxt         = pe_r;
    esc_nxt        = esc_r;
    oe_nxt         = oe_r;
    fe_nxt         = fe_r;
    prev_esc_nxt   = prev_esc_r;
    sync_nxt       = sync_r;
    tx_on_nxt      = tx_enable_bit_in;

    // Transmit side: disable clears and wins over any same-cycle event
    if (!tx_enable_bit_in) begin
      thr_empty_nxt  = 1'b0;
      tx_idle_nxt    = 1'b0;
      tx_started_nxt = 1'b0;
    end else begin
      // Enabling asks for the first character once, setting the empty flag whatever it held
      if (!tx_on_r) begin
        thr_empty_nxt = 1'b1;
      end
      if (tx_hold_write_in) begin
        thr_empty_nxt = 1'b0;
        tx_idle_nxt   = 1'b0;
      end
      if (tx_hold_load_in) begin
        thr_empty_nxt  = 1'b1;
        tx_started_nxt = 1'b1;
      end
      // Fill characters do not mask this in sync mode
      if (tx_shift_done_in && tx_started_r) begin
        tx_idle_nxt = 1'b1;
      end
    end

    // Modem change: read clears, a fresh change wins
    if (status_rd) begin
      mchg_nxt = 1'b0;
    end
    if (modem_change) begin
      mchg_nxt = 1'b1;
    end

    // Receive side clears
    if (!rx_enable_bit_in) begin
      rhr_full_nxt = 1'b0;
      pe_nxt       = 1'b0;
      esc_nxt      = 1'b0;
      oe_nxt       = 1'b0;
      fe_nxt       = 1'b0;
      prev_esc_nxt = 1'b0;
      sync_nxt     = SSF_HUNT;
    end else begin
      if (rx_hold_read_in) begin
        rhr_full_nxt = 1'b0;
      end
      if (reset_error_cmd_in) begin
        pe_nxt  = 1'b0;
        esc_nxt = 1'b0;
        oe_nxt  = 1'b0;
        if (mode == SSF_ASYNC) begin
          fe_nxt = 1'b0;
        end
      end
      if (status_rd && mode != SSF_ASYNC) begin
        fe_nxt = 1'b0;
      end
      if (rx_char_valid_in) begin
        rhr_full_nxt = 1'b1;
        if (rhr_full_r && !rx_hold_read_in) begin
          oe_nxt = 1'b1;
        end
        if (parity_enable_bit_in && rx_parity_err_in) begin
          pe_nxt = 1'b1;
        end
        unique case (mode)
          SSF_ASYNC: begin
            if (rx_stop_err_in) begin
              fe_nxt = 1'b1;
            end
          end
          SSF_SYNC_NORMAL, SSF_SYNC_TRANSP: begin
            unique case (sync_r)
              SSF_HUNT: begin
                if (is_s1) begin
                  if (single_sync_in) begin
                    sync_hit = 1'b1;
                    sync_nxt = SSF_INSYN;
                  end else begin
                    sync_nxt = SSF_SYNC2;
                  end
                end
              end
              SSF_SYNC2: begin
                if (is_s2) begin
                  sync_hit = 1'b1;
                  sync_nxt = SSF_INSYN;
                end else if (!is_s1) begin
                  sync_nxt = SSF_HUNT;
                end
              end
              SSF_INSYN: begin
                if (mode == SSF_SYNC_NORMAL) begin
                  if (single_sync_in && is_s1) begin
                    sync_hit = 1'b1;
                  end else if (is_s1) begin
                    sync_nxt = SSF_SYNC2;
                  end
                end else if (prev_esc_r && is_s1) begin
                  sync_hit = 1'b1;
                end
              end
              default: sync_nxt = SSF_HUNT;
            endcase
            if (sync_hit) begin
              fe_nxt = 1'b1;
            end
            if (mode == SSF_SYNC_TRANSP && !parity_enable_bit_in) begin
              // Escape meaning ends on the next character loaded
              esc_nxt = prev_esc_r && !is_s1 && !is_esc;
            end
            // Escape-escape pair: only the first one counts
            prev_esc_nxt = is_esc && !prev_esc_r;
          end
          default: fe_nxt = fe_r;
        endcase
      end
    end

    status_nxt[`SSF_BIT_TX_HOLDING_EMPTY_FLAG] = thr_empty_nxt;
    status_nxt[`SSF_BIT_RX_HOLDING_FULL_FLAG] = rhr_full_nxt;
    status_nxt[`SSF_BIT_TXEMT] = tx_idle_nxt || mchg_nxt;
    status_nxt[`SSF_BIT_PE]    = pe_nxt || esc_nxt;
    status_nxt[`SSF_BIT_OE]    = oe_nxt;
    status_nxt[`SSF_BIT_FE]    = fe_nxt;
    status_nxt[`SSF_BIT_DCD]   = !dcd_n_in;
    status_nxt[`SSF_BIT_DSR]   = !dsr_n_in;
    pins_nxt = ~status_nxt[`SSF_BIT_TXEMT:`SSF_BIT_TX_HOLDING_EMPTY_FLAG];
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      thr_empty_r  <= 1'b0;
      rhr_full_r   <= 1'b0;
      tx_started_r <= 1'b0;
      tx_idle_r    <= 1'b0;
      mchg_r       <= 1'b0;
      pe_r         <= 1'b0;
      esc_r        <= 1'b0;
      oe_r         <= 1'b0;
      fe_r         <= 1'b0;
      prev_esc_r   <= 1'b0;
      tx_on_r      <= 1'b0;
      sync_r       <= SSF_HUNT;
      status_r     <= `SSF_FLAGS_RESET;
      pins_r       <= 3'b111;
    end else begin
      thr_empty_r  <= thr_empty_nxt;
      rhr_full_r   <= rhr_full_nxt;
      tx_started_r <= tx_started_nxt;
      tx_idle_r    <= tx_idle_nxt;
      mchg_r       <= mchg_nxt;
      pe_r         <= pe_nxt;
      esc_r        <= esc_nxt;
      oe_r         <= oe_nxt;
      fe_r         <= fe_nxt;
      prev_esc_r   <= prev_esc_nxt;
      tx_on_r      <= tx_on_nxt;
      sync_r       <= sync_nxt;
      status_r     <= status_nxt;
      pins_r       <= pins_nxt;
    end
  end

  assign line_status_out               = status_r;
  assign tx_holding_empty_flag_n_out   = pins_r[0];
  assign rx_holding_full_flag_n_out    = pins_r[1];
  assign tx_idle_or_modem_change_n_out = pins_r[2];
endmodule : ssflag_status

// ### verification/ssflag_chk_assertions.sv
`timescale 1ns/1ps
// ****
// Status flag checker
// ****
module ssflag_chk (
  input wire logic       mclk_in,
  input wire logic       srst_in,
  input wire logic       ce_n_in,
  input wire logic [1:0] addr_in,
  input wire logic       rw_in,
  input wire logic       rx_hold_read_in,
  input wire logic       reset_error_cmd_in,
  input wire logic       tx_enable_bit_in,
  input wire logic       rx_enable_bit_in,
  input wire logic       sync_mode_in,
  input wire logic       parity_enable_bit_in,
  input wire logic       tx_hold_write_in,
  input wire logic       tx_hold_load_in,
  input wire logic       rx_char_valid_in,
  input wire logic       rx_parity_err_in,
  input wire logic       rx_stop_err_in,
  input wire logic       dcd_n_in,
  input wire logic       dsr_n_in,
  input wire logic [7:0] line_status_out,
  input wire logic       tx_holding_empty_flag_n_out,
  input wire logic       rx_holding_full_flag_n_out,
  input wire logic       tx_idle_or_modem_change_n_out
);
  wire [7:0] ls = line_status_out;
  wire       rd = !ce_n_in && addr_in == 2'h1 && !rw_in;
  wire       rxv = rx_enable_bit_in && rx_char_valid_in;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  chk_pin_levels: assert property (
    {tx_holding_empty_flag_n_out, rx_holding_full_flag_n_out,
     tx_idle_or_modem_change_n_out} == ~{ls[0], ls[1], ls[2]}) else $error("pin levels");
  chk_mirror_bits: assert property (!$past(srst_in) |->
    ls[7:6] == ~$past({dsr_n_in, dcd_n_in})) else $error("modem mirror");
  chk_modem_flag: assert property (!$past(srst_in) && !$past(srst_in, 2) &&
    $changed({dcd_n_in, dsr_n_in}) |-> ##[1:2] ls[2]) else $error("modem change");
  chk_tx_write: assert property (
    tx_enable_bit_in && tx_hold_write_in && !tx_hold_load_in |=> !ls[0]) else $error("tx write");
  chk_tx_off: assert property (!tx_enable_bit_in |=> !ls[0]) else $error("tx off");
  chk_rx_off: assert property (
    !rx_enable_bit_in |=> (ls & 8'h3a) == 8'h00) else $error("rx off");
  chk_ovr_set: assert property (
    rxv && ls[1] && !rx_hold_read_in |=> ls[4]) else $error("overrun set");
  chk_ovr_keep: assert property (
    ls[4] && rx_enable_bit_in && !reset_error_cmd_in |=> ls[4]) else $error("overrun kept");
  chk_parity_set: assert property (
    rxv && rx_parity_err_in && parity_enable_bit_in |=> ls[3]) else $error("parity");
  chk_frame_set: assert property (
    rxv && rx_stop_err_in && !sync_mode_in |=> ls[5]) else $error("framing");
  chk_sync_clear: assert property (
    sync_mode_in && rx_enable_bit_in && rd && !rx_char_valid_in |=> !ls[5]) else $error("sync");
  chk_err_clear: assert property (
    reset_error_cmd_in && !rx_char_valid_in |=> !ls[4] && !ls[3]) else $error("reset-error");
endmodule : ssflag_chk
bind ssflag_status ssflag_chk u_chk (.*);

// ### verification/ssflag_host.sv
`timescale 1ns/1ps
// ****
// Host bus model
// ****
module ssflag_host (
  input  wire logic  mclk_in,
  output logic       ce_n_out,
  output logic [1:0] addr_out,
  output logic       rw_out,
  output logic       rx_hold_read_out,
  output logic       reset_error_cmd_out
);
  initial begin
    ce_n_out = 1'h1;
    addr_out = 2'h2;
    rw_out = 1'h1;
    rx_hold_read_out = 1'h0;
    reset_error_cmd_out = 1'h0;
  end
  // 0 status read, 1 receive read, 2 reset-error command
  task automatic op(input logic [1:0] k);
    @(posedge mclk_in);
    ce_n_out <= 1'h0;
    addr_out <= (k == 2'h0) ? 2'h1 : {k[1], k[1]};
    rw_out <= k[1];
    rx_hold_read_out <= (k == 2'h1);
    reset_error_cmd_out <= (k == 2'h2);
    @(posedge mclk_in);
    ce_n_out <= 1'h1;
    // Released lines drift so a stale value never looks valid
    addr_out <= ~addr_out;
    rw_out <= ~rw_out;
    rx_hold_read_out <= 1'h0;
    reset_error_cmd_out <= 1'h0;
  endtask : op
endmodule : ssflag_host

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'h0, srst_in = 1'h1, ce_n_in, rw_in, rx_hold_read_in, reset_error_cmd_in;
  logic [1:0] addr_in;
  logic tx_enable_bit_in = 1'h0, rx_enable_bit_in = 1'h0, sync_mode_in = 1'h0;
  logic single_sync_in = 1'h1, transparent_select_in = 1'h0, parity_enable_bit_in = 1'h0;
  logic tx_hold_write_in = 1'h0, tx_hold_load_in = 1'h0, tx_shift_done_in = 1'h0;
  logic rx_char_valid_in = 1'h0, rx_parity_err_in = 1'h0, rx_stop_err_in = 1'h0;
  logic [7:0] rx_char_in = 8'h00, first_sync_char_in = 8'h16, second_sync_char_in = 8'h2c;
  logic [7:0] escape_char_in = 8'h10, line_status_out, r;
  logic dcd_n_in = 1'h1, dsr_n_in = 1'h1;
  logic tx_holding_empty_flag_n_out, rx_holding_full_flag_n_out, tx_idle_or_modem_change_n_out;
  int num_errors = 0, n_checks = 0, cyc = 0;
  integer seed = 32'h181b_9832;
  ssflag_status u_ssflag_status (.*);
  ssflag_host u_ssflag_host (
    .mclk_in             (mclk_in),
    .ce_n_out            (ce_n_in),
    .addr_out            (addr_in),
    .rw_out              (rw_in),
    .rx_hold_read_out    (rx_hold_read_in),
    .reset_error_cmd_out (reset_error_cmd_in)
  );
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  function automatic logic [7:0] mdm(input logic d, input logic s);
    return {~s, ~d, 6'h00};
  endfunction : mdm
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic sts(input string n, input logic [7:0] m, input logic [7:0] e);
    @(negedge mclk_in);
    chk(n, line_status_out & m, e);
  endtask : sts
  task automatic pl(input logic [2:0] p);
    @(posedge mclk_in);
    {tx_shift_done_in, tx_hold_load_in, tx_hold_write_in} <= p;
    @(posedge mclk_in);
    {tx_shift_done_in, tx_hold_load_in, tx_hold_write_in} <= 3'h0;
  endtask : pl
  task automatic cfg(input logic [5:0] v);
    @(posedge mclk_in);
    {tx_enable_bit_in, rx_enable_bit_in, sync_mode_in, single_sync_in,
     transparent_select_in, parity_enable_bit_in} <= v;
  endtask : cfg
  task automatic rx(input logic [7:0] c, input logic p, input logic s);
    @(posedge mclk_in);
    rx_char_valid_in <= 1'h1;
    rx_char_in <= c;
    rx_parity_err_in <= p;
    rx_stop_err_in <= s;
    @(posedge mclk_in);
    rx_char_valid_in <= 1'h0;
    rx_char_in <= ~c;
  endtask : rx
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // ****
  // Main sequence
  // ****
  initial begin
    r = $random(seed);
    // Disjoint ranges keep sync, second sync and escape distinct
    first_sync_char_in <= {1'h1, r[6:0]};
    second_sync_char_in <= {2'h1, r[5:0]};
    escape_char_in <= {3'h1, r[4:0]};
    repeat (19) @(posedge mclk_in);
    sts("reset", 8'hff, 8'h00);
    cfg(6'h2c);
    srst_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    sts("tx on", 8'h07, 8'h01);
    pl(3'h1);
    @(posedge mclk_in);
    sts("tx write", 8'h07, 8'h00);
    chk("ready pin", {7'h00, tx_holding_empty_flag_n_out}, 8'h01);
    pl(3'h2);
    sts("tx load", 8'h07, 8'h01);
    pl(3'h4);
    sts("tx idle", 8'h07, 8'h05);
    chk("idle pin", {7'h00, tx_idle_or_modem_change_n_out}, 8'h00);
    u_ssflag_host.op(2'h0);
    u_ssflag_host.op(2'h0);
    sts("idle reads", 8'h04, 8'h04);
    pl(3'h1);
    sts("idle write", 8'h07, 8'h00);
    pl(3'h2);
    pl(3'h4);
    cfg(6'h0c);
    @(posedge mclk_in);
    sts("tx off", 8'h07, 8'h00);
    $display("test tx done");
    @(posedge mclk_in);
    dcd_n_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    sts("modem", 8'hc4, mdm(1'h0, 1'h1) | 8'h04);
    u_ssflag_host.op(2'h0);
    sts("modem read", 8'h04, 8'h00);
    u_ssflag_host.op(2'h0);
    sts("modem reread", 8'h04, 8'h00);
    repeat (24) begin
      r = $random(seed);
      @(posedge mclk_in);
      {dsr_n_in, dcd_n_in} <= r[1:0];
      @(posedge mclk_in);
      sts("mirror", 8'hc0, mdm(r[0], r[1]));
    end
    $display("test modem done");
    cfg(6'h14);
    r = $random(seed);
    rx(r, 1'h0, 1'h0);
    sts("rx full", 8'h12, 8'h02);
    chk("rx pin", {7'h00, rx_holding_full_flag_n_out}, 8'h00);
    rx(~r, 1'h0, 1'h0);
    sts("overrun", 8'h12, 8'h12);
    u_ssflag_host.op(2'h1);
    u_ssflag_host.op(2'h0);
    sts("overrun kept", 8'h12, 8'h10);
    u_ssflag_host.op(2'h2);
    sts("overrun clr", 8'h10, 8'h00);
    cfg(6'h15);
    rx(8'h00, 1'h1, 1'h1);
    sts("pe fe", 8'h3a, 8'h2a);
    u_ssflag_host.op(2'h0);
    sts("fe read", 8'h20, 8'h20);
    u_ssflag_host.op(2'h2);
    sts("err clr", 8'h28, 8'h00);
    rx(r, 1'h1, 1'h1);
    sts("all err", 8'h3a, 8'h3a);
    cfg(6'h05);
    @(posedge mclk_in);
    sts("rx off", 8'h3a, 8'h00);
    // Random parity enable and error qualifiers in async mode
    repeat (8) begin
      r = $random(seed);
      cfg({5'h0a, r[0]});
      rx(r, r[1], r[2]);
      sts("rand err", 8'h28, {2'h0, r[2], 1'h0, r[0] & r[1], 3'h0});
      u_ssflag_host.op(2'h2);
    end
    $display("test async done");
    cfg(6'h1c);
    rx(first_sync_char_in, 1'h0, 1'h0);
    sts("single sync", 8'h20, 8'h20);
    u_ssflag_host.op(2'h0);
    sts("sync read", 8'h20, 8'h00);
    cfg(6'h08);
    cfg(6'h18);
    rx(first_sync_char_in, 1'h0, 1'h0);
    sts("half pair", 8'h20, 8'h00);
    rx(second_sync_char_in, 1'h0, 1'h0);
    sts("sync pair", 8'h20, 8'h20);
    cfg(6'h0a);
    cfg(6'h1a);
    rx(first_sync_char_in, 1'h0, 1'h0);
    rx(second_sync_char_in, 1'h0, 1'h0);
    sts("tr sync", 8'h20, 8'h20);
    u_ssflag_host.op(2'h0);
    rx(escape_char_in, 1'h0, 1'h0);
    rx(8'h41, 1'h0, 1'h0);
    sts("escape", 8'h28, 8'h08);
    rx(8'h42, 1'h0, 1'h0);
    sts("escape clr", 8'h08, 8'h00);
    rx(escape_char_in, 1'h0, 1'h0);
    rx(first_sync_char_in, 1'h0, 1'h0);
    sts("esc sync", 8'h20, 8'h20);
    @(posedge mclk_in);
    srst_in <= 1'h1;
    @(posedge mclk_in);
    sts("master reset", 8'hff, 8'h00);
    $display("test sync done");
    print_verdict();
  end
endmodule : testbench
